/* core/ntc_pkg.sv */
package ntc_pkg;

    // clock and tick timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SLOW_TICK_NS  = 3200;
    localparam int FAST_TICK_NS  = 320;
    localparam int RT_TICK_NS    = 800;
    localparam int SLOW_TICK_CYC = SLOW_TICK_NS / CLK_PERIOD_NS;
    localparam int FAST_TICK_CYC = FAST_TICK_NS / CLK_PERIOD_NS;
    localparam int RT_TICK_CYC   = RT_TICK_NS / CLK_PERIOD_NS;
    localparam int PRE_W         = 10;

    // register bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_LATENCY  = 8'h1a;
    localparam logic [7:0] IDX_FREE_TIMER   = 8'h34;
    localparam logic [7:0] IDX_DOWNCOUNTER  = 8'h36;
    localparam logic [7:0] IDX_SCHED_CLOCK  = 8'h40;
    localparam logic [7:0] IDX_CTRL         = 8'h50;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h51;
    localparam logic [7:0] IDX_IRQ_MASK     = 8'h52;
    localparam logic [7:0] IDX_COMMAND      = 8'h53;

    // control register fields
    localparam int CTRL_TICK_RATE_BIT  = 0;
    localparam int CTRL_START_MODE_BIT = 1;
    localparam int CTRL_ARMED_BIT      = 2;

    // command register fields (write only, self clearing)
    localparam int CMD_CHIP_RESET_BIT = 0;
    localparam int CMD_FORCE_IRQ_BIT  = 1;

    // irq status / mask layout
    localparam int IRQ_W             = 2;
    localparam int IRQ_REQUESTED_BIT = 0;
    localparam int IRQ_FORCED_BIT    = 1;

    // reset values and latency ceiling
    localparam logic [15:0]      DOWNCOUNT_RST = 16'h0000;
    localparam logic [15:0]      FREE_RST      = 16'h0000;
    localparam logic [31:0]      SCHED_RST     = 32'h0000_0000;
    localparam logic [7:0]       LATENCY_RST   = 8'h00;
    localparam logic [7:0]       LATENCY_MAX   = 8'hff;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST  = 2'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ntc_reg_req_s;

    typedef struct packed {
        logic        valid;
        logic        load_launch_flag;
        logic [31:0] launch_time_field;
    } ntc_sched_req_s;

endpackage

/* core/ntc_timers.sv */
// How it works
// - 16-bit read/write downcounter, zero after reset
// - start mode zero: count down from written value
// - downcount tick 3.2 us slow, 320 ns fast
// - downcounter wraps from zero to ffff
// - start mode one: wait for download done
// - one-to-zero while armed raises requested interrupt
// - nonzero write to downcounter arms expiry
// - zero write or zero crossing disarms expiry
// - 16-bit free timer at selected tick rate
// - free timer cleared by reset and command
// - 32-bit schedule clock ticks every 800 ns
// - launch when schedule clock reaches launch time
// - load flag loads clock, launches at once
// - schedule clock zero after reset
// - 8-bit latency counter restarts on irq assertion
// - latency ticks each 3.2 us, sticks at ff
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// cycle prescaler behind every tick of the block: tick marks the last
// cycle of a period; a restart clears the count but does not suppress a
// tick in the same cycle, and a reload always begins a full period
module ntc_prescaler
#(
    parameter int W = 10
)
(
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // period control
    input  wire logic         run,
    input  wire logic         restart,
    input  wire logic [W-1:0] limit,
    // period end
    output logic              tick
);
    import ntc_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } ntc_presc_state_s;

    ntc_presc_state_s s;
    ntc_presc_state_s next_s;

    // >= rather than == so that a limit lowered mid-period cannot leave
    // the count stranded above it
    assign tick = run && (s.cnt >= limit);

    always_comb
    begin
        next_s = s;
        if (restart)
        begin
            next_s.cnt = '0;
        end
        else if (tick)
        begin
            next_s.cnt = '0;
        end
        else if (run)
        begin
            next_s.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

module ntc_timers
#(
    // prescaler periods in clock cycles; each must fit in PRE_W bits
    parameter int SLOW_CYC = ntc_pkg::SLOW_TICK_CYC,
    parameter int FAST_CYC = ntc_pkg::FAST_TICK_CYC,
    parameter int RT_CYC   = ntc_pkg::RT_TICK_CYC
)
(
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // register port
    input  wire ntc_pkg::ntc_reg_req_s   reg_req,
    output logic [ntc_pkg::DATA_W-1:0]   reg_rdata,
    // dma side
    input  wire logic                    download_done_flag,
    input  wire ntc_pkg::ntc_sched_req_s sched_req,
    output logic                         sched_go,
    // interrupt
    output logic                         irq
);
    import ntc_pkg::*;

    typedef struct packed {
        logic [15:0]       dc_cnt;
        logic              armed;
        logic              dc_run;
        logic              dl_prev;
        logic              rate;
        logic              mode;
        logic [IRQ_W-1:0]  mask;
        logic [IRQ_W-1:0]  status;
        logic [15:0]       free;
        logic [31:0]       rt;
        logic [7:0]        lat;
        logic              lat_run;
        logic              irq;
        logic              sched_go;
        logic [DATA_W-1:0] rdata;
    } ntc_state_s;

    localparam logic [PRE_W-1:0] SLOW_LIM = PRE_W'(SLOW_CYC - 1);
    localparam logic [PRE_W-1:0] FAST_LIM = PRE_W'(FAST_CYC - 1);
    localparam logic [PRE_W-1:0] RT_LIM   = PRE_W'(RT_CYC - 1);

    localparam ntc_state_s STATE_RST = '{
        dc_cnt:  DOWNCOUNT_RST,
        armed:   1'b0,
        dc_run:  1'b0,
        dl_prev: 1'b0,
        rate:    1'b0,
        mode:    1'b0,
        mask:    IRQ_MASK_RST,
        status:  '0,
        free:    FREE_RST,
        rt:      SCHED_RST,
        lat:     LATENCY_RST,
        lat_run: 1'b0,
        irq:     1'b0,
        sched_go: 1'b0,
        rdata:   '0
    };

    ntc_state_s s;
    ntc_state_s next_s;

    logic [7:0]       idx;
    logic             aligned;
    logic             sel_tick;
    logic             exp_ev;
    logic             force_ev;
    logic             wr_dc;
    logic             rd_status;
    logic [IRQ_W-1:0] set_ev;
    logic [PRE_W-1:0] sel_limit;
    logic             rt_tick;
    logic             rt_load;
    logic             lat_tick;
    logic             lat_start;

    // the select limit and the schedule clock restart are made outside the
    // main process; lat_start comes from it, but tick ignores restart, so no loop
    assign sel_limit = s.rate ? FAST_LIM : SLOW_LIM;
    assign rt_load   = sched_req.valid && sched_req.load_launch_flag
                       && !s.sched_go;

    // the schedule clock restarts its period when it is loaded, and the
    // latency count on each fresh interrupt
    ntc_prescaler
    #(
        .W (PRE_W)
    )
    u_sel_prescaler
    (
        // clock and reset
        .clock   (clock),
        .rst_n   (rst_n),
        // period control
        .run     (1'b1),
        .restart (1'b0),
        .limit   (sel_limit),
        .tick    (sel_tick)
    );

    ntc_prescaler
    #(
        .W (PRE_W)
    )
    u_rt_prescaler
    (
        // clock and reset
        .clock   (clock),
        .rst_n   (rst_n),
        // period control
        .run     (1'b1),
        .restart (rt_load),
        .limit   (RT_LIM),
        .tick    (rt_tick)
    );

    ntc_prescaler
    #(
        .W (PRE_W)
    )
    u_lat_prescaler
    (
        // clock and reset
        .clock   (clock),
        .rst_n   (rst_n),
        // period control
        .run     (s.lat_run),
        .restart (lat_start),
        .limit   (SLOW_LIM),
        .tick    (lat_tick)
    );

    always_comb
    begin
        next_s    = s;
        idx       = reg_req.addr[9:2];
        aligned   = (reg_req.addr[1:0] == 2'b00);
        exp_ev    = 1'b0;
        force_ev  = 1'b0;
        wr_dc     = 1'b0;
        rd_status = 1'b0;
        set_ev    = '0;
        next_s.sched_go = 1'b0;
        next_s.rdata    = '0;
        next_s.dl_prev  = download_done_flag;

        // free timer and downcounter share the selectable tick
        if (sel_tick)
        begin
            next_s.free = s.free + 16'h0001;
        end

        // downcounter wraps naturally through zero
        if (!s.dc_run && (!s.mode || (download_done_flag && !s.dl_prev)))
        begin
            next_s.dc_run = 1'b1;
        end
        if (s.dc_run && sel_tick)
        begin
            next_s.dc_cnt = s.dc_cnt - 16'h0001;
            if (s.dc_cnt == 16'h0001)
            begin
                exp_ev       = s.armed;
                next_s.armed = 1'b0;
            end
        end

        // schedule clock and launch decision
        if (rt_tick)
        begin
            next_s.rt = s.rt + 32'h0000_0001;
        end
        if (sched_req.valid && !s.sched_go)
        begin
            if (sched_req.load_launch_flag)
            begin
                next_s.rt       = sched_req.launch_time_field;
                next_s.sched_go = 1'b1;
            end
            else if (s.rt >= sched_req.launch_time_field)
            begin
                next_s.sched_go = 1'b1;
            end
        end

        // register writes; a write beats a same-cycle tick
        if (reg_req.wr && aligned)
        begin
            if (idx == IDX_DOWNCOUNTER)
            begin
                wr_dc         = 1'b1;
                next_s.dc_cnt = reg_req.wdata[15:0];
                next_s.armed  = |reg_req.wdata[15:0];
                next_s.dc_run = !s.mode;
            end
            else if (idx == IDX_CTRL)
            begin
                next_s.rate = reg_req.wdata[CTRL_TICK_RATE_BIT];
                next_s.mode = reg_req.wdata[CTRL_START_MODE_BIT];
            end
            else if (idx == IDX_IRQ_MASK)
            begin
                next_s.mask = reg_req.wdata[IRQ_W-1:0];
            end
            else if (idx == IDX_COMMAND)
            begin
                if (reg_req.wdata[CMD_CHIP_RESET_BIT])
                begin
                    next_s.free = FREE_RST;
                end
                force_ev = reg_req.wdata[CMD_FORCE_IRQ_BIT];
            end
        end

        // reads: only the status register has a side effect
        if (reg_req.rd && aligned)
        begin
            if (idx == IDX_IRQ_LATENCY)
            begin
                next_s.rdata = {24'h000000, s.lat};
            end
            else if (idx == IDX_FREE_TIMER)
            begin
                next_s.rdata = {16'h0000, s.free};
            end
            else if (idx == IDX_DOWNCOUNTER)
            begin
                next_s.rdata = {16'h0000, s.dc_cnt};
            end
            else if (idx == IDX_SCHED_CLOCK)
            begin
                next_s.rdata = s.rt;
            end
            else if (idx == IDX_CTRL)
            begin
                next_s.rdata[CTRL_TICK_RATE_BIT]  = s.rate;
                next_s.rdata[CTRL_START_MODE_BIT] = s.mode;
                next_s.rdata[CTRL_ARMED_BIT]      = s.armed;
            end
            else if (idx == IDX_IRQ_STATUS)
            begin
                rd_status                 = 1'b1;
                next_s.rdata[IRQ_W-1:0]   = s.status;
            end
            else if (idx == IDX_IRQ_MASK)
            begin
                next_s.rdata[IRQ_W-1:0]   = s.mask;
            end
        end

        // sticky status: an event in the clearing cycle survives
        set_ev[IRQ_REQUESTED_BIT] = exp_ev && !wr_dc;
        set_ev[IRQ_FORCED_BIT]    = force_ev;
        next_s.status = (rd_status ? '0 : s.status) | set_ev;
        next_s.irq    = |(next_s.status & next_s.mask);

        // latency counter restarts only on a fresh assertion, so a
        // pending interrupt keeps it from starting again
        lat_start = next_s.irq && !s.irq;
        if (lat_start)
        begin
            next_s.lat     = LATENCY_RST;
            next_s.lat_run = 1'b1;
        end
        else if (lat_tick && (s.lat != LATENCY_MAX))
        begin
            next_s.lat = s.lat + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= STATE_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign sched_go  = s.sched_go;
    assign irq       = s.irq;

endmodule

`default_nettype wire

/* sim/ntc_timers_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module ntc_timers_checker
(
    // clock and reset
    input wire logic                       clock,
    input wire logic                       rst_n,
    // observed ports
    input wire ntc_pkg::ntc_reg_req_s      reg_req,
    input wire logic [ntc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                       download_done_flag,
    input wire ntc_pkg::ntc_sched_req_s    sched_req,
    input wire logic                       sched_go,
    input wire logic                       irq
);
    import ntc_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // status only drops through a register access
    wire logic acc = reg_req.rd | reg_req.wr;

    rdata_idle_a:
    assert property (!$past(reg_req.rd) |-> reg_rdata == '0)
        else $error("read data outside read cycle");
    go_pulse_a:
    assert property (sched_go |=> !sched_go)
        else $error("launch pulse too long");
    load_go_a:
    assert property (sched_req.valid && sched_req.load_launch_flag
                     && !sched_go |=> sched_go)
        else $error("load request not launched");
    go_cause_a:
    assert property (sched_go |-> $past(sched_req.valid))
        else $error("launch without request");
    irq_fall_a:
    assert property ($fell(irq) |-> $past(acc) || $past(acc, 2))
        else $error("irq dropped without access");
    unaligned_a:
    assert property (reg_req.rd && reg_req.addr[1:0] != 2'h0
                     |=> reg_rdata == '0)
        else $error("unaligned read not zero");
    cmd_zero_a:
    assert property (reg_req.rd && reg_req.addr == 10'h14c
                     |=> reg_rdata == '0)
        else $error("command read not zero");
    lat_width_a:
    assert property (reg_req.rd && reg_req.addr == 10'h068
                     |=> reg_rdata[31:8] == 24'h0)
        else $error("latency upper bits set");

    cover property (sched_go);
    cover property ($rose(irq));
    cover property (reg_req.rd && reg_req.addr == 10'h0d8);
endmodule

bind ntc_timers ntc_timers_checker u_ntc_timers_checker
(
    .clock, .rst_n, .reg_req, .reg_rdata,
    .download_done_flag, .sched_req, .sched_go, .irq
);

`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
    import ntc_pkg::*;
    logic           clock = 1'b0;
    logic           rst_n = 1'b0;
    ntc_reg_req_s   req   = '0;
    ntc_sched_req_s sq    = '0;
    logic           dn    = 1'b0;
    logic [31:0]    rdata;
    logic           go;
    logic           irq;
    int             errors = 0;
    int             comparisons = 0;
    int             cyc = 0;

    always #2 clock = ~clock;

    ntc_timers u_ntc_timers
    (
        .clock              (clock),
        .rst_n              (rst_n),
        .reg_req            (req),
        .reg_rdata          (rdata),
        .download_done_flag (dn),
        .sched_req          (sq),
        .sched_go           (go),
        .irq                (irq)
    );

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, lo, hi);
        comparisons++;
        if ((g >= lo && g <= hi) !== 1'b1)
        begin
            errors++;
            $display("Error %0t got %h", $time, g);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] lo, hi);
        @(posedge clock);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 chk(rdata, lo, hi);
    endtask

    // bounded wait on launch pulse (g=1) or irq (g=0)
    task automatic wt(input bit g, input int n);
        while ((g ? go : irq) !== 1'b1 && n > 0)
        begin
            @(posedge clock);
            #1 n--;
        end
        chk(g ? go : irq, 1, 1);
    endtask

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            print_verdict;
        end
    end

    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rd(10'h068, 0, 0);
        rd(10'h0d8, 0, 0);
        rd(10'h100, 0, 0);
        rd(10'h0da, 0, 0);
        rd(10'h14c, 0, 0);
        wr(10'h0d0, 5);
        rd(10'h0d0, 0, 0);
        wr(10'h140, 1);
        wr(10'h148, 1);
        wr(10'h0d8, 3);
        rd(10'h140, 5, 5);
        wt(0, 400);
        rd(10'h0d8, 0, 0);
        rd(10'h140, 1, 1);
        repeat (100) @(posedge clock);
        rd(10'h0d8, 16'hffff, 16'hffff);
        rd(10'h144, 1, 1);
        rd(10'h144, 0, 0);
        chk(irq, 0, 0);
        wr(10'h0d8, 2);
        wr(10'h0d8, 0);
        rd(10'h140, 1, 1);
        repeat (300) @(posedge clock);
        rd(10'h144, 0, 0);
        wr(10'h0d8, 16'h0100);
        repeat (800) @(posedge clock);
        rd(10'h0d8, 16'h00f5, 16'h00f7);
        wr(10'h140, 0);
        wr(10'h14c, 1);
        rd(10'h0d0, 0, 1);
        repeat (1600) @(posedge clock);
        rd(10'h0d0, 2, 3);
        wr(10'h140, 3);
        wr(10'h0d8, 4);
        repeat (400) @(posedge clock);
        rd(10'h0d8, 4, 4);
        @(posedge clock);
        dn <= 1'b1;
        wt(0, 500);
        rd(10'h144, 1, 1);
        @(posedge clock);
        dn <= 1'b0;
        // pending status is clear here, so forcing starts the latency count
        wr(10'h148, 3);
        wr(10'h14c, 2);
        wt(0, 10);
        rd(10'h068, 0, 0);
        repeat (1000) @(posedge clock);
        rd(10'h068, 1, 1);
        rd(10'h144, 2, 2);
        @(posedge clock);
        sq <= '{valid: 1'b1, load_launch_flag: 1'b1,
                launch_time_field: 32'h100};
        wt(1, 5);
        @(posedge clock);
        sq.valid <= 1'b0;
        rd(10'h100, 32'h100, 32'h100);
        @(posedge clock);
        sq <= '{valid: 1'b1, load_launch_flag: 1'b0,
                launch_time_field: 32'h102};
        wt(1, 700);
        @(posedge clock);
        sq.valid <= 1'b0;
        rd(10'h100, 32'h102, 32'h102);
        print_verdict;
    end
endmodule

`default_nettype wire
